// File: verilog/wdlp_pkg.sv
// Purpose: shared constants and types for the low-power watchdog
// Assumes: 250 MHz system clock, 8-bit control register on a 32-bit Wishbone bus
// Notes: every offset, field position and timing figure lives here
// ============================================================
// package
package wdlp_pkg;
    // ============================================================
    // register map (index times four gives the byte address)
    localparam logic [7:0] WDLP_CTRL_IDX = 8'h2a;
    localparam logic [7:0] WDLP_CTRL_ADDR = {WDLP_CTRL_IDX[5:0], 2'b00};
    localparam logic [7:0] WDLP_CTRL_RESET = 8'h7f;
    localparam int WDLP_ACT_BIT = 7;
    localparam int WDLP_TOP_BIT = 6;
    localparam int WDLP_CNT_W = 7;
    localparam logic [6:0] WDLP_CNT_ROLL = 7'h40;
    localparam logic [6:0] WDLP_CNT_ONE = 7'h01;
    localparam logic [31:0] WDLP_DAT_ZERO = 32'h0000_0000;

    // ============================================================
    // timing
    localparam int WDLP_CLK_MHZ = 250;
    localparam int WDLP_PRESCALE_DEF = 16384;
    localparam int WDLP_RST_PULSE_US = 30;
    // longest time: whole cycles, rounded down
    localparam int WDLP_RST_PULSE_CYC = WDLP_RST_PULSE_US * WDLP_CLK_MHZ;
    localparam int WDLP_RESUME_SHORT = 256;
    localparam int WDLP_RESUME_LONG = 4096;
    localparam int WDLP_DLY_W = 13;
    localparam logic [12:0] WDLP_DLY_SHORT_LAST = 13'(WDLP_RESUME_SHORT - 1);
    localparam logic [12:0] WDLP_DLY_LONG_LAST = 13'(WDLP_RESUME_LONG - 1);

    // ============================================================
    // types
    typedef enum logic [1:0] {
        WDLP_ST_RUN = 2'b00,
        WDLP_ST_HALT_FROZEN = 2'b01,
        WDLP_ST_ACT_HALT = 2'b10,
        WDLP_ST_RESUME_WAIT = 2'b11
    } wdlp_state_t;

    // option byte straps, sampled from pins
    typedef struct packed {
        logic hw_watchdog;
        logic halt_reset_option;
        logic long_resume;
    } wdlp_opt_t;

    // core signals on the same clock
    typedef struct packed {
        logic halt_req;
        logic osc_irq_enable;
        logic osc_irq;
    } wdlp_cpu_t;
endpackage

// File: verilog/wdlp_rst_pulse.sv
// Purpose: stretch a watchdog reset request into a timed reset pin pulse
// Assumes: start_i is a single-cycle request on clk_i
// Notes: a request before the pulse's last cycle is absorbed into it; one in the last cycle starts a new pulse
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// reset pulse stretcher
module wdlp_rst_pulse #(
    parameter int unsigned CYCLES = 7500
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // request
    input wire logic start_i,
    // pulse outputs
    output logic busy_o,
    output logic pin_oe_o
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
    localparam logic [CW-1:0] ZERO = '0;
    localparam logic [CW-1:0] ONE = CW'(1);

    logic [CW-1:0] cnt_ff;
    logic busy_ff;
    wire done = busy_ff && (cnt_ff == LAST);
    wire [CW-1:0] nxt_cnt = busy_ff ? (done ? ZERO : cnt_ff + ONE) : ZERO;
    wire nxt_busy = start_i || (busy_ff && !done);

    // pulse length is exact; a restart would only lengthen an already-held reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= ZERO;
            busy_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            busy_ff <= nxt_busy;
        end
    end

    assign busy_o = busy_ff;
    assign pin_oe_o = busy_ff; // driving the pin low
endmodule
`default_nettype wire

// File: verilog/wdlp_watchdog.sv
// Purpose: watchdog with low-power mode handling and one control register
// Assumes: Wishbone classic slave, 32-bit data, single clock at 250 MHz
// Notes: the prescaler is never cleared by writes, so timeouts carry jitter
//
// Our own choice: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module wdlp_watchdog #(
    parameter int unsigned PRESCALE_CYCLES = wdlp_pkg::WDLP_PRESCALE_DEF,
    parameter int unsigned RST_PULSE_CYCLES = wdlp_pkg::WDLP_RST_PULSE_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // core state, same clock
    input wire wdlp_pkg::wdlp_cpu_t cpu_i,
    // pins: external interrupt and option straps
    input wire logic ext_irq_i,
    input wire wdlp_pkg::wdlp_opt_t opt_i,
    // reset outputs
    output logic device_reset_o,
    output logic reset_pin_o,
    output logic reset_pin_oe_o
);
    localparam int PW = $clog2(PRESCALE_CYCLES);
    localparam logic [PW-1:0] PS_LAST = PW'(PRESCALE_CYCLES - 1);
    localparam logic [PW-1:0] PS_ZERO = '0;
    localparam logic [PW-1:0] PS_ONE = PW'(1);
    localparam logic [12:0] DLY_ZERO = '0;
    localparam logic [12:0] DLY_ONE = 13'h0001;

    // one step down of the 7-bit counter, wrapping 00h to 7Fh
    function automatic logic [6:0] dec7(input logic [6:0] v);
        dec7 = v - wdlp_pkg::WDLP_CNT_ONE;
    endfunction

    // ============================================================
    // pin synchronisers
    logic [3:0] pin_s1_ff;
    logic [3:0] pin_s2_ff;
    wire wdlp_pkg::wdlp_opt_t opt_s = pin_s2_ff[2:0];
    wire ext_irq_s = pin_s2_ff[3];

    // straps and the interrupt pin are asynchronous to clk_i
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_ff <= 4'h0;
            pin_s2_ff <= 4'h0;
        end else begin
            pin_s1_ff <= {ext_irq_i, opt_i};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // ============================================================
    // wishbone decode
    logic ack_ff;
    logic [31:0] dat_ff;
    logic act_ff;
    logic [6:0] cnt_ff;
    wire bus_req = wb_cyc_i && wb_stb_i;
    wire bus_hit = (wb_adr_i == wdlp_pkg::WDLP_CTRL_ADDR);
    // writes land on the edge where the master sees ack
    wire bus_wr = bus_req && ack_ff && wb_we_i && bus_hit && wb_sel_i[0];
    wire [7:0] wr_byte = wb_dat_i[7:0];
    wire [31:0] rd_word = bus_hit ? {24'h000000, act_ff, cnt_ff} : wdlp_pkg::WDLP_DAT_ZERO;

    // one wait state; unmapped addresses answer with zero data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= wdlp_pkg::WDLP_DAT_ZERO;
        end else begin
            ack_ff <= bus_req && !ack_ff;
            dat_ff <= rd_word;
        end
    end

    // ============================================================
    // prescaler, free running so its phase at a write is unknown
    logic [PW-1:0] ps_ff;
    wire tick = (ps_ff == PS_LAST);
    wire [PW-1:0] nxt_ps = tick ? PS_ZERO : ps_ff + PS_ONE;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ps_ff <= PS_ZERO;
        end else begin
            ps_ff <= nxt_ps;
        end
    end

    // ============================================================
    // low-power state and resume delay
    wdlp_pkg::wdlp_state_t state_ff;
    wdlp_pkg::wdlp_state_t nxt_state;
    logic [12:0] dly_ff;
    wire st_run = (state_ff == wdlp_pkg::WDLP_ST_RUN);
    wire st_frozen = (state_ff == wdlp_pkg::WDLP_ST_HALT_FROZEN);
    wire st_act = (state_ff == wdlp_pkg::WDLP_ST_ACT_HALT);
    wire st_wait = (state_ff == wdlp_pkg::WDLP_ST_RESUME_WAIT);
    wire active = act_ff || opt_s.hw_watchdog;
    wire halt_go = st_run && cpu_i.halt_req;
    wire halt_active = halt_go && cpu_i.osc_irq_enable;
    wire halt_reset = halt_go && !cpu_i.osc_irq_enable && opt_s.halt_reset_option;
    wire halt_plain = halt_go && !cpu_i.osc_irq_enable && !opt_s.halt_reset_option;
    wire [12:0] dly_last = opt_s.long_resume ? wdlp_pkg::WDLP_DLY_LONG_LAST
                                             : wdlp_pkg::WDLP_DLY_SHORT_LAST;
    wire dly_done = st_wait && (dly_ff == dly_last);
    wire [12:0] nxt_dly = st_wait ? dly_ff + DLY_ONE : DLY_ZERO;

    // next power state; frozen halt returns to run only through the wait
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            wdlp_pkg::WDLP_ST_RUN: begin
                if (halt_active) begin
                    nxt_state = wdlp_pkg::WDLP_ST_ACT_HALT;
                end else if (halt_plain) begin
                    nxt_state = wdlp_pkg::WDLP_ST_HALT_FROZEN;
                end
            end
            wdlp_pkg::WDLP_ST_HALT_FROZEN: begin
                if (ext_irq_s) begin
                    nxt_state = wdlp_pkg::WDLP_ST_RESUME_WAIT;
                end
            end
            wdlp_pkg::WDLP_ST_ACT_HALT: begin
                if (cpu_i.osc_irq || ext_irq_s) begin
                    nxt_state = wdlp_pkg::WDLP_ST_RUN;
                end
            end
            wdlp_pkg::WDLP_ST_RESUME_WAIT: begin
                if (dly_done) begin
                    nxt_state = wdlp_pkg::WDLP_ST_RUN;
                end
            end
            default: begin
                nxt_state = wdlp_pkg::WDLP_ST_RUN;
            end
        endcase
    end

    // every reset, including one that ends a halt, starts in the resume delay
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= wdlp_pkg::WDLP_ST_RESUME_WAIT;
            dly_ff <= DLY_ZERO;
        end else begin
            state_ff <= nxt_state;
            dly_ff <= nxt_dly;
        end
    end

    // ============================================================
    // control register: activate bit and counter
    wire dec_now = (st_run && tick) || halt_plain;
    wire [6:0] nxt_cnt = bus_wr ? wr_byte[wdlp_pkg::WDLP_TOP_BIT:0]
                                : (dec_now ? dec7(cnt_ff) : cnt_ff);
    // software can only set the bit; clearing needs a reset
    wire nxt_act = act_ff || (bus_wr && wr_byte[wdlp_pkg::WDLP_ACT_BIT]);
    wire roll = st_run && tick && !halt_plain && !bus_wr
                && (cnt_ff == wdlp_pkg::WDLP_CNT_ROLL);
    wire roll_fire = roll && active;
    wire wr_fire = bus_wr && !st_frozen && !wr_byte[wdlp_pkg::WDLP_TOP_BIT]
                   && (nxt_act || opt_s.hw_watchdog);
    wire fire = roll_fire || wr_fire || halt_reset;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            act_ff <= wdlp_pkg::WDLP_CTRL_RESET[wdlp_pkg::WDLP_ACT_BIT];
            cnt_ff <= wdlp_pkg::WDLP_CTRL_RESET[wdlp_pkg::WDLP_TOP_BIT:0];
        end else begin
            act_ff <= nxt_act;
            cnt_ff <= nxt_cnt;
        end
    end

    // ============================================================
    // reset pulse
    logic pulse_busy;
    logic pulse_oe;

    wdlp_rst_pulse #(
        .CYCLES(RST_PULSE_CYCLES)
    ) u_pulse (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(fire),
        .busy_o(pulse_busy),
        .pin_oe_o(pulse_oe)
    );

    // ============================================================
    // outputs, no interrupt line exists
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    assign device_reset_o = pulse_busy;
    assign reset_pin_oe_o = pulse_oe;
    assign reset_pin_o = 1'b0; // open drain: only ever pulls low

    // ============================================================
    // check helper: cycles spent in the current resume delay
    // kept apart from dly_ff so a stuck or skipped delay count still shows
    logic [12:0] wait_len_ff;
    wire [12:0] nxt_wait_len = st_wait ? wait_len_ff + DLY_ONE : DLY_ZERO;

    // a plain counter stands in for a 4096-cycle delay range in the checks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_len_ff <= DLY_ZERO;
        end else begin
            wait_len_ff <= nxt_wait_len;
        end
    end

    // ============================================================
    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_halt_plain;
        halt_plain && !bus_wr;
    endsequence
    sequence s_frozen_hold;
        st_frozen && !ext_irq_s;
    endsequence

    a_rollover_fires: assert property (roll_fire |=> device_reset_o)
        else $error("rollover while active gave no reset");
    a_soft_reset: assert property (wr_fire |=> device_reset_o ##1 device_reset_o)
        else $error("write clearing top bit gave no reset");
    a_halt_freeze: assert property (s_halt_plain ##1 s_frozen_hold |=> $stable(cnt_ff))
        else $error("counter moved while frozen in halt");
    a_halt_one_dec: assert property (s_halt_plain |=> cnt_ff == dec7($past(cnt_ff)) && st_frozen)
        else $error("halt entry did not decrement exactly once");
    a_halt_reset_opt: assert property (halt_reset |=> device_reset_o && !st_frozen)
        else $error("halt with reset option did not reset");
    a_act_halt_hold: assert property (st_act && $past(st_act) && !$past(bus_wr)
                                      |-> $stable(cnt_ff))
        else $error("counter moved in active halt");
    a_act_wake_now: assert property (st_act && cpu_i.osc_irq |=> st_run)
        else $error("active halt wake was delayed");
    a_resume_wait: assert property ($rose(st_wait) |-> st_wait [*8])
        else $error("resume delay ended too early");
    // resume delay length, measured by wait_len_ff
    a_resume_bound: assert property (st_wait |-> wait_len_ff <= dly_last)
        else $error("resume delay did not end in time");
    a_resume_length: assert property ($fell(st_wait)
                                      |-> $past(wait_len_ff) == $past(dly_last))
        else $error("resume delay ended at the wrong cycle");
    a_wait_holds_cnt: assert property (st_wait && $past(st_wait) && !$past(bus_wr)
                                       |-> $stable(cnt_ff))
        else $error("counter moved during the resume delay");
    a_act_sticky: assert property (act_ff |=> act_ff)
        else $error("activate bit cleared without reset");
    a_hw_active: assert property (roll && opt_s.hw_watchdog |=> device_reset_o)
        else $error("hardware option rollover gave no reset");
    // counter and reset behaviour in run, and the reset pin level
    a_free_run: assert property (st_run && tick && !bus_wr
                                 |=> cnt_ff == dec7($past(cnt_ff)))
        else $error("counter missed a prescaler step");
    a_no_roll_inactive: assert property (roll && !active && !halt_reset && !pulse_busy
                                         |=> !device_reset_o)
        else $error("rollover reset while watchdog inactive");
    a_pin_low: assert property (device_reset_o |-> reset_pin_oe_o && !reset_pin_o)
        else $error("reset pin not pulled low during reset");
    // bus handshake, wake-up path and no reset while frozen
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge stood longer than one cycle");
    a_ext_wake_frozen: assert property (st_frozen && ext_irq_s |=> st_wait)
        else $error("external wake did not start the resume delay");
    a_no_frozen_fire: assert property (st_frozen |-> !fire)
        else $error("reset issued while frozen in halt");
endmodule
`default_nettype wire

// File: tb/tb_watchdog_low_power_control.sv
// Purpose: self-checking bench for the low-power watchdog
// Assumes: prescale shortened to 16 cycles, reset pulse to 8, short resume delay strap
// Notes: prescaler phase is unknown at writes, so count checks allow one or two steps of slack
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// bench top
module tb_watchdog_low_power_control;
    localparam int PRE = 16;
    localparam int PULSE = 8;
    localparam logic [7:0] ctl_adr = wdlp_pkg::WDLP_CTRL_ADDR;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [3:0] sel_n = 4'hf;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic device_reset_o;
    logic reset_pin_o;
    logic reset_pin_oe_o;
    logic ext_irq_i = 1'b0;
    wdlp_pkg::wdlp_cpu_t cpu_i = '0;
    wdlp_pkg::wdlp_opt_t opt_i = '0;
    int miscompares = 0;
    int num_checks = 0;

    wdlp_watchdog #(.PRESCALE_CYCLES(PRE), .RST_PULSE_CYCLES(PULSE)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_i(cpu_i), .ext_irq_i(ext_irq_i),
        .opt_i(opt_i), .device_reset_o(device_reset_o), .reset_pin_o(reset_pin_o),
        .reset_pin_oe_o(reset_pin_oe_o));

    // ============================================================
    // helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // register word as the bus returns it: byte lane 0 only
    function automatic logic [31:0] exp_word(input logic [7:0] b);
        return {24'h000000, b};
    endfunction

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // classic single cycle; ack is sampled at the edge, request released there
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d,
                      output logic [31:0] rd);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel_n;
        wb_dat_i <= {24'h000000, d};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (k >= 20) begin
            miscompares++;
            final_report();
        end
    endtask

    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    // single-cycle pulse on one core line: 2 halt, 0 oscillator wake
    task automatic core_pulse(input int b);
        @(posedge clk_i);
        cpu_i[b] <= 1'b1;
        @(posedge clk_i);
        cpu_i[b] <= 1'b0;
    endtask

    // reset must start within lo..hi cycles and stand exactly the pulse length
    task automatic expect_reset(input int lo, input int hi);
        int n;
        int w;
        n = 0;
        while (device_reset_o !== 1'b1 && n <= hi) begin
            @(posedge clk_i);
            n++;
        end
        chk(32'(n >= lo && n <= hi), 32'h1);
        chk({30'h0, reset_pin_oe_o, reset_pin_o}, 32'h2);
        w = 0;
        while (device_reset_o === 1'b1 && w < 100) begin
            @(posedge clk_i);
            w++;
        end
        chk(32'(w), 32'(PULSE));
    endtask

    task automatic expect_quiet(input int n);
        int hits;
        hits = 0;
        repeat (n) begin
            @(posedge clk_i);
            hits += int'(device_reset_o !== 1'b0);
        end
        chk(32'(hits), 32'h0);
    endtask

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    // hang guard: long enough for every resume delay in the sequence
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        final_report();
    end

    // ============================================================
    // main sequence
    initial begin
        logic [31:0] r;
        logic [31:0] r1;
        logic [7:0] v;
        void'($urandom(32'h2601e08b));
        do_reset();
        // counter holds during the post-reset delay, so readback is exact
        wb(1'b0, ctl_adr, 8'h00, r);
        chk(r, exp_word(wdlp_pkg::WDLP_CTRL_RESET));
        wb(1'b0, 8'h04, 8'h00, r);
        chk(r, 32'h0000_0000);
        for (int i = 0; i < 6; i++) begin
            v = {1'b0, 7'($urandom)};
            wb(1'b1, ctl_adr, v, r);
            wb(1'b0, ctl_adr, 8'h00, r);
            chk(r, exp_word(v));
        end
        sel_n = 4'he;
        wb(1'b1, ctl_adr, 8'hd5, r);
        sel_n = 4'hf;
        repeat (100) @(posedge clk_i);
        wb(1'b0, ctl_adr, 8'h00, r);
        chk(r, {24'h000000, v});
        $display("test readback done");
        // free-running count while inactive
        repeat (200) @(posedge clk_i);
        wb(1'b1, ctl_adr, 8'h7f, r);
        repeat (PRE * 5) @(posedge clk_i);
        wb(1'b0, ctl_adr, 8'h00, r);
        chk(32'(r[7:0] inside {[8'h78 : 8'h7a]}), 32'h1);
        // rollover while still inactive must stay silent
        wb(1'b1, ctl_adr, 8'h41, r);
        expect_quiet(PRE * 3);
        // activate, then try to clear it: rollover still resets
        wb(1'b1, ctl_adr, 8'hc2, r);
        wb(1'b1, ctl_adr, 8'h42, r);
        expect_reset(28, 52);
        wb(1'b0, ctl_adr, 8'h00, r);
        chk({31'h0, r[7]}, 32'h1);
        do_reset();
        wb(1'b0, ctl_adr, 8'h00, r);
        chk(r, 32'h0000_007f);
        $display("test rollover done");
        // software reset by clearing the top bit while activating
        repeat (260) @(posedge clk_i);
        wb(1'b1, ctl_adr, 8'hbf, r);
        expect_reset(0, 3);
        do_reset();
        // halt with reset option
        opt_i.halt_reset_option <= 1'b1;
        repeat (260) @(posedge clk_i);
        core_pulse(2);
        expect_reset(0, 3);
        opt_i.halt_reset_option <= 1'b0;
        do_reset();
        $display("test soft reset done");
        // active halt holds the count, oscillator wake resumes at once
        repeat (260) @(posedge clk_i);
        wb(1'b1, ctl_adr, 8'hff, r);
        cpu_i.osc_irq_enable <= 1'b1;
        core_pulse(2);
        wb(1'b0, ctl_adr, 8'h00, r1);
        expect_quiet(PRE * 4);
        wb(1'b0, ctl_adr, 8'h00, r);
        chk(r, r1);
        core_pulse(0);
        repeat (PRE * 3) @(posedge clk_i);
        cpu_i.osc_irq_enable <= 1'b0;
        wb(1'b0, ctl_adr, 8'h00, r);
        chk(32'(r[6:0] < r1[6:0]), 32'h1);
        $display("test active halt done");
        // plain halt: one more step, then frozen with resets held off
        wb(1'b1, ctl_adr, 8'hc2, r);
        core_pulse(2);
        wb(1'b0, ctl_adr, 8'h00, r1);
        chk(32'(r1 inside {32'hc1, 32'hc0}), 32'h1);
        expect_quiet(PRE * 6);
        wb(1'b0, ctl_adr, 8'h00, r);
        chk(r, r1);
        @(posedge clk_i);
        ext_irq_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        ext_irq_i <= 1'b0;
        expect_quiet(240);
        expect_reset(0, 64);
        do_reset();
        wb(1'b0, ctl_adr, 8'h00, r);
        chk(r, 32'h0000_007f);
        $display("test plain halt done");
        // hardware option: activation bit not needed
        opt_i.hw_watchdog <= 1'b1;
        do_reset();
        repeat (260) @(posedge clk_i);
        wb(1'b1, ctl_adr, 8'h41, r);
        expect_reset(10, 40);
        opt_i.hw_watchdog <= 1'b0;
        $display("test hardware option done");
        final_report();
    end
endmodule
`default_nettype wire
